// ==== include/mls_pkg.sv ====
// Constants for the modem line status and scratchpad block
package mls_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned IDX_W  = 4;
  localparam int unsigned LINES  = 4;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] MCTL_IDX     = 4'h4;
  localparam logic [IDX_W-1:0] MLS_IDX      = 4'h6;
  localparam logic [IDX_W-1:0] SCRATCH_IDX  = 4'h7;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 4'h8;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 4'h9;

  // Line order inside every four-bit vector; change bit i pairs with level bit i+4
  localparam int unsigned LN_CTS = 0;
  localparam int unsigned LN_DSR = 1;
  localparam int unsigned LN_RI  = 2;
  localparam int unsigned LN_DCD = 3;

  // Modem control fields
  localparam int unsigned MCTL_DTR  = 0;
  localparam int unsigned MCTL_RTS  = 1;
  localparam int unsigned MCTL_USER_OUTPUT_ONE = 2;
  localparam int unsigned MCTL_USER_OUTPUT_TWO = 3;
  localparam int unsigned MCTL_LOOP = 4;
  localparam int unsigned MCTL_W    = 5;

  // Reset values
  localparam logic [MCTL_W-1:0] MCTL_RST     = 5'h00;
  localparam logic [REG_W-1:0]  SCRATCH_RST  = 8'hFF;
  localparam logic [LINES-1:0]  IRQ_MASK_RST = 4'h0;
  localparam logic [LINES-1:0]  PINS_IDLE    = 4'hF;

  // Input priming: cycles before change detection is trusted
  localparam int unsigned PRIME_CYC = 3;
endpackage

// ==== include/mls_line_if.sv ====
// Carrier between the register bank and its line synchroniser
`timescale 1ns/100ps
`default_nettype none
interface mls_line_if;
  logic       lpbk;    // Loopback mode
  logic [3:0] lb_src;  // Asserted levels used in loopback
  logic [3:0] lvl;     // Asserted line levels, 1 = pin low
  logic [3:0] chg;     // One-cycle change pulses
  modport ctrl (output lpbk, output lb_src, input lvl, input chg);
  modport line (input lpbk, input lb_src, output lvl, output chg);
endinterface
`default_nettype wire

// ==== logic/mls_line_sync.sv ====
// Synchroniser and change detector for the four modem inputs
`timescale 1ns/100ps
`default_nettype none
module mls_line_sync
  import mls_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // Active-low modem pins
  input  wire logic [mls_pkg::LINES-1:0] pins_n_i,
  // Register bank side
  mls_line_if.line                      lnk
);
  import mls_pkg::*;

  logic [LINES-1:0]     meta_q;
  logic [LINES-1:0]     sync_q;
  logic [LINES-1:0]     prev_q;
  logic [PRIME_CYC-1:0] prime_q;
  logic [LINES-1:0]     cur;
  logic [LINES-1:0]     toggled;
  logic                 armed;

  // Two flops per pin; the first is read only by the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
    end else if (ce_i) begin
      meta_q <= pins_n_i;
      sync_q <= meta_q;
    end
  end

  // Loopback swaps the pins for the control bits
  assign cur = lnk.lpbk ? lnk.lb_src : ~sync_q;

  // Previous level, plus priming so a pin held low at reset is no change
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q  <= '0;
      prime_q <= '0;
    end else if (ce_i) begin
      prev_q  <= cur;
      prime_q <= {prime_q[PRIME_CYC-2:0], 1'b1};
    end
  end

  assign armed   = prime_q[PRIME_CYC-1];
  assign toggled = (cur ^ prev_q) & {LINES{armed}};

  // Ring only counts its trailing edge: asserted level falls as pin goes 0 to 1
  assign lnk.chg[LN_CTS] = toggled[LN_CTS];
  assign lnk.chg[LN_DSR] = toggled[LN_DSR];
  assign lnk.chg[LN_RI]  = armed & prev_q[LN_RI] & ~cur[LN_RI];
  assign lnk.chg[LN_DCD] = toggled[LN_DCD];
  assign lnk.lvl         = cur;
endmodule
`default_nettype wire

// ==== logic/mls_regs.sv ====
// Modem line status, scratchpad and modem control registers behind APB
`timescale 1ns/100ps
`default_nettype none
module mls_regs
  import mls_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  // APB slave
  input  wire logic [mls_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [mls_pkg::DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]                  pstrb_i,
  output logic      [mls_pkg::DATA_W-1:0]  prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  // Active-low modem inputs
  input  wire logic                        dcd_n_i,
  input  wire logic                        ri_n_i,
  input  wire logic                        dsr_n_i,
  input  wire logic                        cts_n_i,
  // Active-low modem outputs
  output logic                             dtr_n_o,
  output logic                             rts_n_o,
  output logic                             user_output_one_n_o,
  output logic                             user_output_two_n_o,
  // Interrupts
  output logic                             msi_o,
  output logic                             irq_o
);
  import mls_pkg::*;

  // Address decode shared by every register
  // Upper bits and the byte offset must be zero, so aliases of a
  // register never answer as if they were mapped
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [IDX_W-1:0]  idx);
    logic upper_zero;
    upper_zero = (a[ADDR_W-1:IDX_W+2] == '0);
    return upper_zero && (a[1:0] == 2'b00) && (a[IDX_W+1:2] == idx);
  endfunction

  // Set-wins update for any sticky flag set
  // Shared by the change flags and the interrupt status, so both
  // follow one priority rule
  function automatic logic [LINES-1:0] sticky(input logic [LINES-1:0] q,
                                              input logic [LINES-1:0] clr,
                                              input logic [LINES-1:0] set);
    return (q & ~clr) | set;
  endfunction

  // Register state
  logic [MCTL_W-1:0]  mctl_q;
  logic [MCTL_W-1:0]  mctl_d;
  logic [REG_W-1:0]   scratch_q;
  logic [REG_W-1:0]   scratch_d;
  logic [LINES-1:0]   delta_q;
  logic [LINES-1:0]   delta_d;
  logic [LINES-1:0]   capt_q;
  logic [LINES-1:0]   capt_d;
  logic [LINES-1:0]   irq_stat_q;
  logic [LINES-1:0]   irq_stat_d;
  logic [LINES-1:0]   irq_mask_q;
  logic [LINES-1:0]   irq_mask_d;
  logic [DATA_W-1:0]  rdata_q;
  logic [DATA_W-1:0]  rdata_d;
  logic               slverr_q;
  logic               slverr_d;
  logic [LINES-1:0]   pins_n_q;
  logic [LINES-1:0]   pins_n_d;

  // Bus phase decode
  logic               setup;
  logic               access;
  logic               wr_done;
  logic               rd_done;
  logic               lane0;
  logic               sel_mctl;
  logic               sel_mls;
  logic               sel_scr;
  logic               sel_istat;
  logic               sel_imask;
  logic               mapped;

  // Write strobes per register
  logic               wr_mctl;
  logic               wr_scr;
  logic               wr_istat;
  logic               wr_imask;
  logic               rd_mls;
  logic [LINES-1:0]   rd_clr;
  logic [LINES-1:0]   istat_clr;

  // Read views
  logic [REG_W-1:0]   mls_view;
  logic [DATA_W-1:0]  rd_mux;
  logic [LINES-1:0]   lb_src;
  logic [LINES-1:0]   pins_n;

  // Line synchroniser link
  // The synchroniser owns the pins; this module only sees asserted levels
  mls_line_if lnk ();

  assign pins_n[LN_CTS] = cts_n_i;
  assign pins_n[LN_DSR] = dsr_n_i;
  assign pins_n[LN_RI]  = ri_n_i;
  assign pins_n[LN_DCD] = dcd_n_i;

  // Loopback sources sit in line order next to their pins
  assign lb_src[LN_CTS] = mctl_q[MCTL_RTS];
  assign lb_src[LN_DSR] = mctl_q[MCTL_DTR];
  assign lb_src[LN_RI]  = mctl_q[MCTL_USER_OUTPUT_ONE];
  assign lb_src[LN_DCD] = mctl_q[MCTL_USER_OUTPUT_TWO];

  assign lnk.lpbk   = mctl_q[MCTL_LOOP];
  assign lnk.lb_src = lb_src;

  mls_line_sync u_sync (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .ce_i     (ce_i),
    .pins_n_i (pins_n),
    .lnk      (lnk.line)
  );

  // APB phases; a frozen clock enable holds off the completion too
  // Setup and access differ only in penable; a master that skips
  // setup would see stale read data
  assign setup   = psel_i & ~penable_i & ce_i;
  assign access  = psel_i & penable_i & ce_i;
  assign wr_done = access & pwrite_i;
  assign rd_done = access & ~pwrite_i;
  assign lane0   = pstrb_i[0];

  // Register select
  assign sel_mctl  = reg_hit(paddr_i, MCTL_IDX);
  assign sel_mls   = reg_hit(paddr_i, MLS_IDX);
  assign sel_scr   = reg_hit(paddr_i, SCRATCH_IDX);
  assign sel_istat = reg_hit(paddr_i, IRQ_STAT_IDX);
  assign sel_imask = reg_hit(paddr_i, IRQ_MASK_IDX);
  assign mapped    = sel_mctl | sel_mls | sel_scr | sel_istat | sel_imask;

  // Writes only land on byte lane 0; the status register ignores writes
  assign wr_mctl  = wr_done & sel_mctl & lane0;
  assign wr_scr   = wr_done & sel_scr & lane0;
  assign wr_istat = wr_done & sel_istat & lane0;
  assign wr_imask = wr_done & sel_imask & lane0;
  assign rd_mls   = rd_done & sel_mls;

  // Status view: levels above, change flags below
  assign mls_view = {lnk.lvl, delta_q};

  // Read mux feeding the data flop
  // Unmapped addresses fall through to zero, paired with the error flag
  assign rd_mux = sel_mls   ? {{(DATA_W-REG_W){1'b0}}, mls_view} :
                  sel_scr   ? {{(DATA_W-REG_W){1'b0}}, scratch_q} :
                  sel_mctl  ? {{(DATA_W-MCTL_W){1'b0}}, mctl_q} :
                  sel_istat ? {{(DATA_W-LINES){1'b0}}, irq_stat_q} :
                  sel_imask ? {{(DATA_W-LINES){1'b0}}, irq_mask_q} :
                  32'h0000_0000;

  // Read data and error are taken in setup, so the access phase shows flops
  assign rdata_d  = setup ? (pwrite_i ? 32'h0000_0000 : rd_mux) : rdata_q;
  assign slverr_d = setup ? ~mapped : slverr_q;

  // Only the flags that went out in the read data are cleared, so an edge
  // arriving between setup and access survives the clear
  // Trade-off: one extra four-bit register instead of a wait state
  assign capt_d = setup ? ((sel_mls & ~pwrite_i) ? delta_q : '0) : capt_q;
  assign rd_clr = rd_mls ? capt_q : '0;

  // Change flags: set wins over the clearing read
  assign delta_d = sticky(delta_q, rd_clr, lnk.chg);

  // Interrupt status: write one to clear, a new event wins
  assign istat_clr  = wr_istat ? pwdata_i[LINES-1:0] : '0;
  assign irq_stat_d = sticky(irq_stat_q, istat_clr, lnk.chg);

  // Plain read/write registers
  assign mctl_d     = wr_mctl ? pwdata_i[MCTL_W-1:0] : mctl_q;
  assign scratch_d  = wr_scr ? pwdata_i[REG_W-1:0] : scratch_q;
  assign irq_mask_d = wr_imask ? pwdata_i[LINES-1:0] : irq_mask_q;

  // Outputs rest inactive in loopback so the far end sees an idle line
  // Registered so the pins never glitch while the control word changes
  assign pins_n_d[LN_CTS] = ~(mctl_q[MCTL_RTS] & ~mctl_q[MCTL_LOOP]);
  assign pins_n_d[LN_DSR] = ~(mctl_q[MCTL_DTR] & ~mctl_q[MCTL_LOOP]);
  assign pins_n_d[LN_RI]  = ~(mctl_q[MCTL_USER_OUTPUT_ONE] & ~mctl_q[MCTL_LOOP]);
  assign pins_n_d[LN_DCD] = ~(mctl_q[MCTL_USER_OUTPUT_TWO] & ~mctl_q[MCTL_LOOP]);

  // Modem control
  // Holds loopback, both user outputs and the two handshake controls
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mctl_q <= MCTL_RST;
    end else if (ce_i) begin
      mctl_q <= mctl_d;
    end
  end

  // Scratchpad
  // Plain storage for software, read back unchanged
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scratch_q <= SCRATCH_RST;
    end else if (ce_i) begin
      scratch_q <= scratch_d;
    end
  end

  // Change flags and the copy handed out with a read
  // Both move together so a frozen enable cannot split them
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      delta_q <= '0;
      capt_q  <= '0;
    end else if (ce_i) begin
      delta_q <= delta_d;
      capt_q  <= capt_d;
    end
  end

  // Interrupt status and mask
  // Mask resets closed so irq_o fires no request before software is ready
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
    end else if (ce_i) begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // Bus answer flops
  // Loaded only in setup, so they stand through the access phase
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // Modem output pins
  // Reset to the idle high level, so the far end sees nothing asserted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pins_n_q <= PINS_IDLE;
    end else if (ce_i) begin
      pins_n_q <= pins_n_d;
    end
  end

  // APB answer: no wait states
  // Limitation: a low clock enable is the only way the answer stalls
  assign pready_o  = access;
  assign pslverr_o = access & slverr_q;
  assign prdata_o  = rdata_q;

  // Pin drive
  assign rts_n_o  = pins_n_q[LN_CTS];
  assign dtr_n_o  = pins_n_q[LN_DSR];
  assign user_output_one_n_o = pins_n_q[LN_RI];
  assign user_output_two_n_o = pins_n_q[LN_DCD];

  // Modem status request follows the change flags themselves
  // Kept apart from the masked interrupt so channel logic can rank
  // modem events on its own
  assign msi_o = |delta_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// ==== tb/mls_regs_asserts.sv ====
// Port-level assertions for the modem line status register bank
`timescale 1ns/100ps
`default_nettype none
module mls_regs_asserts
  import mls_pkg::*;
(
  // Clock and reset
  input wire logic                       clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       ce_i,
  // APB
  input wire logic [mls_pkg::ADDR_W-1:0] paddr_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [mls_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0]                 pstrb_i,
  input wire logic [mls_pkg::DATA_W-1:0] prdata_o,
  input wire logic                       pready_o,
  input wire logic                       pslverr_o,
  // Modem lines and interrupts
  input wire logic                       dcd_n_i,
  input wire logic                       ri_n_i,
  input wire logic                       dsr_n_i,
  input wire logic                       cts_n_i,
  input wire logic                       dtr_n_o,
  input wire logic                       msi_o,
  input wire logic                       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] pins_q;
  logic [2:0] stab_q;
  logic [3:0] arm_q;
  // Decode of the bus request
  wire [3:0] pins   = {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  wire [3:0] idx    = paddr_i[5:2];
  wire       mapped = (paddr_i[1:0] == 2'h0) && (paddr_i[11:6] == 6'h00) &&
                      (idx == 4'h4 || idx == 4'h6 || idx == 4'h7 || idx == 4'h8 || idx == 4'h9);
  wire       acc    = psel_i & penable_i & pready_o;
  wire       st_rd  = acc & !pwrite_i & (paddr_i == 12'h018);
  // Pin stability and time since reset, so checks skip the synchroniser window
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pins_q <= 4'hF;
      stab_q <= 3'h0;
      arm_q  <= 4'h0;
    end else begin
      pins_q <= pins;
      stab_q <= (pins != pins_q) ? 3'h0 : (stab_q == 3'h7 ? stab_q : stab_q + 3'h1);
      arm_q  <= (arm_q == 4'hF) ? arm_q : arm_q + 4'h1;
    end
  end
  property p_ready; psel_i && penable_i && ce_i |-> pready_o; endproperty
  property p_err; acc && !mapped |-> pslverr_o; endproperty
  property p_ok; acc && mapped |-> !pslverr_o; endproperty
  property p_level;
    st_rd && !dtr_n_o && $past(!dtr_n_o) && stab_q == 3'h7 |-> prdata_o[7:4] == ~pins;
  endproperty
  property p_change;
    arm_q == 4'hF && !dtr_n_o && ($changed(pins & 4'hB) || $rose(ri_n_i)) |-> ##[1:4] msi_o;
  endproperty
  property p_rdclr; $fell(msi_o) |-> $past(st_rd); endproperty
  property p_msi; st_rd |-> (prdata_o[3:0] != 4'h0) == $past(msi_o); endproperty
  property p_dtr;
    acc && pwrite_i && pstrb_i[0] && paddr_i == 12'h010 && pwdata_i[0] && !pwdata_i[4] |-> ##2 !dtr_n_o;
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing in access");
  a_err: assert property (p_err) else $error("no error on unmapped access");
  a_ok: assert property (p_ok) else $error("error on mapped access");
  a_level: assert property (p_level) else $error("line levels wrong");
  a_change: assert property (p_change) else $error("pin change not flagged");
  a_rdclr: assert property (p_rdclr) else $error("flags cleared without read");
  a_msi: assert property (p_msi) else $error("status request not tied to flags");
  a_dtr: assert property (p_dtr) else $error("terminal ready output not driven");
  c_err: cover property (acc && !mapped);
  c_clr: cover property ($fell(msi_o));
  c_irq: cover property ($rose(irq_o));
endmodule
bind mls_regs mls_regs_asserts chk_u (.*);
`default_nettype wire

// ==== tb/mls_modem.sv ====
// Behavioural modem driving the four active-low status pins
`timescale 1ns/100ps
`default_nettype none
module mls_modem (
  // Clock
  input  wire logic       clk_i,
  // Asserted levels, bit order carrier, ring, set-ready, clear-to-send
  input  wire logic [3:0] want_i,
  // Active-low pins
  output logic            dcd_n_o,
  output logic            ri_n_o,
  output logic            dsr_n_o,
  output logic            cts_n_o
);
  // Pins move just after each rising edge, in step with the sampling clock
  always_ff @(posedge clk_i) begin
    {dcd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= ~want_i;
  end
endmodule
`default_nettype wire

// ==== tb/modem_status_scratch_regs_test.sv ====
// Self-checking bench for the modem line status and scratchpad registers
`timescale 1ns/100ps
`default_nettype none
module modem_status_scratch_regs_test;
  import mls_pkg::*;
  localparam logic [11:0] A_CTL = {6'h00, MCTL_IDX, 2'h0};
  localparam logic [11:0] A_MLS = {6'h00, MLS_IDX, 2'h0};
  localparam logic [11:0] A_SCR = {6'h00, SCRATCH_IDX, 2'h0};
  localparam logic [11:0] A_IST = {6'h00, IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] A_IMS = {6'h00, IRQ_MASK_IDX, 2'h0};
  logic        clk_i = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, r, r2;
  logic [3:0]  pstrb = 4'hF, want = 4'h0;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, dcd_n, ri_n, dsr_n, cts_n, dtr_n, rts_n, user_output_one_n, user_output_two_n, msi, irq;
  int          miscompares = 0, checked = 0;
  logic [7:0]  pv [6] = '{8'h01, 8'h03, 8'h07, 8'h03, 8'h0B, 8'h00};
  logic [7:0]  px [6] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hB8, 8'h0B};
  logic [7:0]  lv [4] = '{8'h18, 8'h14, 8'h11, 8'h12};
  logic [7:0]  lx [4] = '{8'h88, 8'h40, 8'h22, 8'h11};
  mls_regs dut_u (.clk_i(clk_i), .rst_n_i(rst_n), .ce_i(1'b1), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .dcd_n_i(dcd_n), .ri_n_i(ri_n), .dsr_n_i(dsr_n),
    .cts_n_i(cts_n), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .user_output_one_n_o(user_output_one_n), .user_output_two_n_o(user_output_two_n),
    .msi_o(msi), .irq_o(irq));
  mls_modem modem_u (.clk_i(clk_i), .want_i(want), .dcd_n_o(dcd_n), .ri_n_o(ri_n), .dsr_n_o(dsr_n),
    .cts_n_o(cts_n));
  // Free-running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk_i);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, {31'h0, pready});
      stop_test();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, 4'hF, r, e);
    chk("prdata", x, r);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF, r, e);
  endtask
  task automatic t_reset();
    rd(A_SCR, 32'h0000_00FF);
    rd(A_CTL, 32'h0000_0000);
    rd(A_IMS, 32'h0000_0000);
    rd(A_MLS, 32'h0000_0000);
  endtask
  task automatic t_scratch();
    wr(A_SCR, 32'h0000_00A5);
    apb(1'b1, A_SCR, 32'h0000_005A, 4'h0, r, e);
    rd(A_SCR, 32'h0000_00A5);
    rd(A_MLS, 32'h0000_0000);
    apb(1'b0, 12'h03C, 32'h0000_0000, 4'hF, r, e);
    chk("pslverr", 32'h0000_0001, {31'h0, e});
    apb(1'b1, 12'h019, 32'h0000_0000, 4'hF, r, e);
    chk("pslverr", 32'h0000_0001, {31'h0, e});
  endtask
  task automatic t_pins();
    wr(A_CTL, 32'h0000_0001);
    cyc(2);
    chk("dtr_n", 32'h0000_0000, {31'h0, dtr_n});
    // Each step but the last moves one line, the last drops three; levels, flags and the request are judged
    for (int i = 0; i < 6; i++) begin
      want <= pv[i][3:0];
      cyc(6);
      chk("msi", {31'h0, px[i][3:0] != 4'h0}, {31'h0, msi});
      rd(A_MLS, {24'h0, px[i]});
      rd(A_MLS, {24'h0, px[i] & 8'hF0});
    end
    // A clear-to-send edge lands on the access edge of a read that clears set-ready
    want <= 4'h2;
    cyc(6);
    want <= 4'h3;
    cyc(1);
    rd(A_MLS, 32'h0000_0022);
    r2 = r;
    cyc(6);
    rd(A_MLS, 32'h0000_0031);
    chk("flag kept", 32'h0000_0001, {31'h0, r[0] | r2[0]});
  endtask
  task automatic t_loop();
    want <= 4'h0;
    cyc(6);
    rd(A_MLS, 32'h0000_0003);
    wr(A_CTL, 32'h0000_0010);
    cyc(3);
    rd(A_MLS, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(A_CTL, {24'h0, lv[i]});
      cyc(3);
      chk("outputs", 32'h0000_000F, {28'h0, dtr_n, rts_n, user_output_one_n, user_output_two_n});
      rd(A_MLS, {24'h0, lx[i]});
      wr(A_CTL, 32'h0000_0010);
      cyc(3);
      rd(A_MLS, {28'h0, lx[i][7:4]});
    end
    // All four controls set outside loopback drive every output low
    wr(A_CTL, 32'h0000_000F);
    cyc(2);
    chk("outputs", 32'h0000_0000, {28'h0, dtr_n, rts_n, user_output_one_n, user_output_two_n});
    wr(A_CTL, 32'h0000_0001);
  endtask
  task automatic t_irq();
    wr(A_IST, 32'h0000_000F);
    want <= 4'h1;
    cyc(6);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(A_IST, 32'h0000_0001);
    wr(A_IMS, 32'h0000_0001);
    rd(A_IMS, 32'h0000_0001);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(A_IST, 32'h0000_0001);
    cyc(1);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(A_MLS, 32'h0000_0011);
  endtask
  // Main sequence
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    cyc(4);
    t_reset();
    t_scratch();
    t_pins();
    t_loop();
    t_irq();
    stop_test();
  end
endmodule
`default_nettype wire
